/* core/factor_pkg.sv */
// Constants shared by the number factor display block and its segment decoder.
// Assumes a single system clock at the rate given by CLK_HZ.
package factor_pkg;
   localparam int NUM_W = 8;
   localparam int MAX_DIV = 19;
   localparam int MAX_SHOWN = 15;
   localparam int POS_W = 4;
   localparam int SUM_W = 8;
   localparam int DBG_W = 8;
   localparam int FLAG_W = 8;
   localparam int SEG_W = 7;
   localparam logic [POS_W-1:0] FIRST_FACTOR = 4'h1;
   localparam logic [POS_W-1:0] LAST_FACTOR = 4'hF;
   localparam int CLK_HZ = 200_000_000;
   localparam int STEP_TIME_MS = 1000;
   localparam int STEP_CYCLES = (CLK_HZ / 1000) * STEP_TIME_MS;
   localparam int PRIMES [FLAG_W] = '{2, 3, 5, 7, 11, 13, 17, 19};
   // Segment patterns, bit 0 is segment a, bit 6 is segment g, lit when high.
   localparam logic [SEG_W-1:0] SEG_TABLE [16] = '{
      7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D, 7'h07,
      7'h7F, 7'h6F, 7'h77, 7'h7C, 7'h39, 7'h5E, 7'h79, 7'h71};

   // Residue of the weight of input bit b modulo divisor k.
   function automatic int bitResidue(input int b, input int k);
      return (1 << b) % k;
   endfunction
endpackage

/* core/hex_segments.sv */
// Combinational binary to hexadecimal seven-segment decoder.
// Assumes the caller registers the pattern before it reaches a pin.
`timescale 1ns/1ps
`default_nettype none
module hex_segments (
   input wire logic [factor_pkg::POS_W-1:0] digit,
   output logic [factor_pkg::SEG_W-1:0] segments
);
   import factor_pkg::*;

   // Decimal digits keep their usual shapes; only A to F use letter shapes.
   always_comb begin
      segments = SEG_TABLE[digit];
   end
endmodule
`default_nettype wire

/* core/number_factor_display.sv */
// Number factor display: finds divisors up to 19 of an 8-bit pin input, steps the
// factors up to 15 on a seven-segment display and flags prime factors on pins.
// Assumes the input pins are asynchronous switches and one clock at CLK_HZ.
//
// Contract
// - Every divisor from 1 to 19 is tested against the number within two cycles.
// - Divisibility is found by summing fixed per-bit residues and testing for a multiple.
// - The residue sum is compared with every multiple of the divisor up to 8 times k-1.
// - With a nonzero number the display steps through factors 1 to 15 and wraps to 1.
// - Each displayed value is held for one second.
// - A clock divider produces the one-second step from the system clock.
// - The displayed value is decoded to a hex digit by combinational logic.
// - Digits 0 to 9 use decimal shapes and only A to F have letter shapes.
// - Eight flag pins show the prime factors 2,3,5,7,11,13,17,19 from low to high bit.
// - The dot is lit only while the number is prime.
// - With a zero number the flag pins carry the low eight bits of a debug counter.
// - The debug counter advances by one every cycle.
// - With a zero number the display counts 1 to F once per second and wraps.
// - With a zero number the dot stays dark.
`timescale 1ns/1ps
`default_nettype none
module number_factor_display #(
   parameter int STEP_CYC = factor_pkg::STEP_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [factor_pkg::NUM_W-1:0] numberPins,
   output logic [factor_pkg::SEG_W-1:0] segments,
   output logic dot,
   output logic [factor_pkg::FLAG_W-1:0] flags
);
   import factor_pkg::*;

   logic [NUM_W-1:0] numMeta_r;
   logic [NUM_W-1:0] numSync_r;
   logic [NUM_W-1:0] numStage1_r;
   logic [NUM_W-1:0] numStage2_r;
   logic [SUM_W-1:0] residueSum_r [MAX_DIV:1];
   logic [MAX_DIV:1] isDiv_r;
   logic [31:0] tickCnt_r;
   logic stepTick;
   logic [DBG_W-1:0] dbgCnt_r;
   logic [POS_W-1:0] pos_r;
   logic [POS_W-1:0] pos_nxt;
   logic [SEG_W-1:0] segDecoded;
   logic [SEG_W-1:0] seg_r;
   logic dot_r;
   logic [FLAG_W-1:0] flags_r;
   logic [FLAG_W-1:0] primeMap;
   logic isPrime;
   logic numZero;

   // The switches are asynchronous, so they pass two flip-flops first.
   always_ff @(posedge clk) begin
      if (rst) begin
         numMeta_r <= '0;
         numSync_r <= '0;
      end else begin
         numMeta_r <= numberPins;
         numSync_r <= numMeta_r;
      end
   end

   // The number is carried alongside the pipeline so results and number stay aligned.
   always_ff @(posedge clk) begin
      if (rst) begin
         numStage1_r <= '0;
         numStage2_r <= '0;
      end else begin
         numStage1_r <= numSync_r;
         numStage2_r <= numStage1_r;
      end
   end

   // One residue adder and one multiple comparator per divisor; the result is two
   // cycles behind the synchronised number, which avoids any real division.
   genvar k;
   generate
      for (k = 1; k <= MAX_DIV; k++) begin : gDiv
         logic [SUM_W-1:0] sumNxt;
         logic hit;
         always_comb begin
            sumNxt = '0;
            for (int b = 0; b < NUM_W; b++) begin
               if (numSync_r[b]) begin
                  sumNxt = sumNxt + SUM_W'(bitResidue(b, k));
               end
            end
         end
         always_comb begin
            hit = 1'b0;
            for (int m = 0; m <= NUM_W; m++) begin
               if (m * k <= NUM_W * (k - 1) && residueSum_r[k] == SUM_W'(m * k)) begin
                  hit = 1'b1;
               end
            end
         end
         // A zero number is divisible by everything, which matches the reset value.
         always_ff @(posedge clk) begin
            if (rst) begin
               residueSum_r[k] <= '0;
               isDiv_r[k] <= 1'b1;
            end else begin
               residueSum_r[k] <= sumNxt;
               isDiv_r[k] <= hit;
            end
         end
      end
   endgenerate

   // Primality from the divisor flags is exact because no 8-bit composite lacks
   // a factor below 16.
   always_comb begin
      isPrime = numStage2_r > 8'h01;
      for (int d = 2; d <= MAX_DIV; d++) begin
         if (isDiv_r[d] && numStage2_r != NUM_W'(d)) begin
            isPrime = 1'b0;
         end
      end
   end

   always_comb begin
      for (int p = 0; p < FLAG_W; p++) begin
         primeMap[p] = isDiv_r[PRIMES[p]];
      end
   end

   assign numZero = numStage2_r == '0;

   // One-second step divider.
   always_ff @(posedge clk) begin
      if (rst) begin
         tickCnt_r <= '0;
      end else if (stepTick) begin
         tickCnt_r <= '0;
      end else begin
         tickCnt_r <= tickCnt_r + 32'h00000001;
      end
   end
   assign stepTick = tickCnt_r == 32'(STEP_CYC - 1);

   always_ff @(posedge clk) begin
      if (rst) begin
         dbgCnt_r <= '0;
      end else begin
         dbgCnt_r <= dbgCnt_r + 8'h01;
      end
   end

   // Next shown value: the next higher factor up to 15, else back to 1. A zero
   // number counts every value because every divisor flag is set for it.
   always_comb begin
      pos_nxt = FIRST_FACTOR;
      for (int c = MAX_SHOWN; c > 1; c--) begin
         if (POS_W'(c) > pos_r && isDiv_r[c]) begin
            pos_nxt = POS_W'(c);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pos_r <= FIRST_FACTOR;
      end else if (stepTick) begin
         pos_r <= pos_nxt;
      end
   end

   hex_segments uHex (
      .digit(pos_r),
      .segments(segDecoded)
   );

   always_ff @(posedge clk) begin
      if (rst) begin
         seg_r <= '0;
         dot_r <= 1'b0;
         flags_r <= '0;
      end else begin
         seg_r <= segDecoded;
         dot_r <= isPrime && !numZero;
         flags_r <= numZero ? dbgCnt_r : primeMap;
      end
   end

   assign segments = seg_r;
   assign dot = dot_r;
   assign flags = flags_r;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_div_latency: assert property (!$past(rst, 3) |->
      isDiv_r[19] == ($past(numSync_r, 2) % 19 == 0))
      else $error("divisor 19 result wrong two cycles after input");
   a_div_three: assert property (isDiv_r[3] == (numStage2_r % 3 == 0))
      else $error("divisor 3 result disagrees with number");
   a_div_thirteen: assert property (isDiv_r[13] == (numStage2_r % 13 == 0))
      else $error("divisor 13 result disagrees with number");
   a_prime_flag_map: assert property (!numZero |=> flags_r == $past(primeMap))
      else $error("prime flags do not follow divisor results");
   a_zero_debug_flags: assert property (numZero |=> flags_r == $past(dbgCnt_r))
      else $error("zero number does not show debug counter");
   a_debug_increment: assert property (!$past(rst) |-> dbgCnt_r == $past(dbgCnt_r) + 8'h01)
      else $error("debug counter did not advance by one");
   a_dot_prime: assert property (dot_r == $past(isPrime && !numZero))
      else $error("dot does not follow primality");
   a_dot_zero_dark: assert property (numZero |=> !dot_r)
      else $error("dot lit for zero number");
   a_prime_seven: assert property (numStage2_r == 8'h07 |-> isPrime)
      else $error("seven not taken as prime");
   a_step_hold: assert property (!stepTick |=> $stable(pos_r))
      else $error("display changed between steps");
   a_step_period: assert property (tickCnt_r < 32'(STEP_CYC))
      else $error("divider ran past its period");
   a_shown_range: assert property (pos_r >= FIRST_FACTOR && pos_r <= LAST_FACTOR)
      else $error("display value out of range");
   a_zero_count_up: assert property (stepTick && numZero |=>
      pos_r == (($past(pos_r) == LAST_FACTOR) ? FIRST_FACTOR : $past(pos_r) + 4'h1))
      else $error("zero number does not count up");
   a_seg_letter: assert property ($past(pos_r) == 4'hA |-> seg_r == 7'h77)
      else $error("letter A pattern wrong");
   a_seg_eight: assert property ($past(pos_r) == 4'h8 |-> seg_r == 7'h7F)
      else $error("digit 8 pattern wrong");
   a_reset_restart: assert property (disable iff (1'b0) rst |=>
      pos_r == FIRST_FACTOR && tickCnt_r == '0 && dbgCnt_r == '0)
      else $error("reset did not restart sequencing");

   c_zero_wrap: cover property (stepTick && numZero && pos_r == LAST_FACTOR);
   c_prime_dot: cover property (dot_r);
   c_factor_step: cover property (stepTick && !numZero && pos_nxt != FIRST_FACTOR);
   c_factor_wrap: cover property (stepTick && !numZero && pos_r != FIRST_FACTOR
      && pos_nxt == FIRST_FACTOR);
endmodule
`default_nettype wire

/* sim/switch_display_model.sv */
// Switch bank and seven-segment display that sit around the factor block.
// Assumes active-high segments with bit 0 as segment a, and switches set by the bench.
`timescale 1ns/1ps
`default_nettype none
module switch_display_model (
   input wire logic [factor_pkg::NUM_W-1:0] switches,
   output logic [factor_pkg::NUM_W-1:0] numberPins,
   input wire logic [factor_pkg::SEG_W-1:0] segments,
   input wire logic dot,
   output logic [factor_pkg::POS_W-1:0] shownDigit,
   output logic shownDot
);
   import factor_pkg::*;
   // Switches are ideal levels; bounce is not modelled.
   assign numberPins = switches;
   assign shownDot = dot;
   // A lamp pattern outside the digit set reads as unknown, so it can never match.
   always_comb begin
      shownDigit = 'x;
      for (int i = 0; i < 16; i++) begin
         if (segments === SEG_TABLE[i]) begin
            shownDigit = 4'(i);
         end
      end
   end
endmodule
`default_nettype wire

/* sim/tb.sv */
// Self-checking bench for the number factor display block.
// Assumes the block's five-edge pin latency and a shortened display step.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import factor_pkg::*;
   localparam int STEP = 20;
   typedef struct {logic [7:0] flg; logic dt; logic [3:0] dig; bit chk;} note_t;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [NUM_W-1:0] switches = 8'h00;
   logic [NUM_W-1:0] numberPins;
   logic [SEG_W-1:0] segments;
   logic dot;
   logic [FLAG_W-1:0] flags;
   logic [POS_W-1:0] shownDigit;
   logic shownDot;
   note_t notes[$];
   int n_fail = 0;
   int n_tests = 0;
   logic [31:0] rng = 32'h00011A55;
   always #2.5 clk = ~clk;
   number_factor_display #(.STEP_CYC(STEP)) i_dut (.clk(clk), .rst(rst),
      .numberPins(numberPins), .segments(segments), .dot(dot), .flags(flags));
   switch_display_model i_far (.switches(switches), .numberPins(numberPins),
      .segments(segments), .dot(dot), .shownDigit(shownDigit), .shownDot(shownDot));
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   function automatic logic [7:0] primeFlags(input logic [7:0] n);
      int p[8] = '{2, 3, 5, 7, 11, 13, 17, 19};
      logic [7:0] f;
      f = 8'h00;
      for (int i = 0; i < 8; i++) begin
         f[i] = (n % p[i] == 0);
      end
      return f;
   endfunction
   // Trial division over every smaller value, independent of the block's divisor set.
   function automatic logic isPrime(input logic [7:0] n);
      logic pr;
      pr = (n > 1);
      for (int d = 2; d < n; d++) begin
         if (n % d == 0) begin
            pr = 1'b0;
         end
      end
      return pr;
   endfunction
   function automatic logic [3:0] nextFactor(input logic [7:0] n, input logic [3:0] cur);
      for (int d = int'(cur) + 1; d <= 15; d++) begin
         if (n % d == 0) begin
            return 4'(d);
         end
      end
      return 4'h1;
   endfunction
   task automatic check(input logic [7:0] a, input logic [7:0] e);
      n_tests++;
      if (a !== e) begin
         n_fail++;
         $display("[FAIL] t=%0t got %h expected %h", $time, a, e);
      end
   endtask
   task automatic final_report();
      $display("Checks %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Reset with the number already on the switches, then sample each display step mid-way.
   task automatic walk(input logic [7:0] n);
      logic [3:0] d;
      rst <= 1'b1;
      switches <= n;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      repeat (10) @(posedge clk);
      d = 4'h1;
      for (int k = 0; k < 18; k++) begin
         notes.push_back('{(n == 8'h00) ? 8'(9 + STEP * k) : primeFlags(n), isPrime(n), d, 1'b1});
         d = nextFactor(n, d);
         repeat (STEP) @(posedge clk);
      end
      $display("Walk of number %0d done", n);
   endtask
   // A new number every cycle; each result is due five edges after its pins change:
   // two synchroniser flops, the residue sum, the divisor flags, then the output flops.
   task automatic stream(input int count);
      logic [7:0] v[$];
      for (int i = 0; i < count + 5; i++) begin
         if (i < count) begin
            rng = xorshift(rng);
            v.push_back((rng[7:0] == 8'h00) ? 8'h01 : rng[7:0]);
            switches <= v[i];
         end
         if (i >= 5) begin
            notes.push_back('{primeFlags(v[i-5]), isPrime(v[i-5]), 4'h0, 1'b0});
         end
         @(posedge clk);
      end
      $display("Stream of %0d numbers done", count);
   endtask
   always @(negedge clk) begin
      note_t e;
      if (notes.size() > 0) begin
         e = notes.pop_front();
         check(flags, e.flg);
         check(8'(shownDot), 8'(e.dt));
         if (e.chk) begin
            check(8'(shownDigit), 8'(e.dig));
         end
      end
   end
   initial begin
      logic [7:0] nums[11] = '{8'h00, 8'h06, 8'h07, 8'h17, 8'h01, 8'hFF, 8'hD2, 8'hDD,
         8'hF7, 8'h02, 8'h13};
      @(posedge clk);
      foreach (nums[i]) begin
         walk(nums[i]);
      end
      for (int i = 0; i < 4; i++) begin
         rng = xorshift(rng);
         walk(rng[7:0]);
      end
      stream(40);
      repeat (2) @(posedge clk);
      final_report();
   end
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      final_report();
   end
endmodule
`default_nettype wire
